// ==== pkg/io_map_cfg.svh ====
// Address map constants for the expanded-mode reference mapper
`ifndef IO_MAP_CFG_SVH
`define IO_MAP_CFG_SVH

// ==========================================================
// Region bases (register numbers, one-based)
`define AUX_TABLE_BASE     13'd1
`define MAIN_REAL_BASE     13'd129
`define AUX_REAL_BASE      13'd1153
`define MAIN_INT_BASE      13'd2049
`define AUX_INT_BASE       13'd3073
// ==========================================================
// Channel geometry
`define WORDS_PER_TYPE     13'd64
`define WORDS_PER_CHAN     13'd128
`define LAST_REAL_POINT    11'd1000
`define LAST_POINT         11'd1024
`define AUX_FIRST_CHAN     4'h8
`define BIT_FIELD_W        4

`endif

// ==== pkg/io_map_pkg.sv ====
// Types shared by the reference mapper and its scan sequencer
package io_map_pkg;

  typedef enum logic [2:0] {
    DEST_MAIN_STATUS = 3'h0,
    DEST_AUX_STATUS  = 3'h1,
    DEST_REAL_REG    = 3'h2,
    DEST_INT_REG     = 3'h3,
    DEST_INVALID     = 3'h4
  } dest_e;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_RUN  = 2'b01,
    SCAN_DONE = 2'b11
  } scan_state_e;

  typedef logic [3:0]  chan_t;
  typedef logic [10:0] point_t;
  typedef logic [12:0] reg_num_t;

endpackage

// ==== pkg/scan_if.sv ====
// Link between the mapper top and its channel scan sequencer
`timescale 1ns/1ps
interface scan_if;
  import io_map_pkg::*;
  logic        start;
  logic [15:0] chan_enable;
  logic        busy;
  logic        chan_valid;
  chan_t       chan;
  logic        done;

  modport ctrl (output start, output chan_enable,
                input busy, input chan_valid, input chan, input done);
  modport seq  (input start, input chan_enable,
                output busy, output chan_valid, output chan, output done);
endinterface

// ==== rtl/scan_seq.sv ====
// Channel scan sequencer: walks all sixteen channels in order, flagging the selected ones
`timescale 1ns/1ps
module scan_seq (
  input  wire logic clk,
  input  wire logic rst_b,
  scan_if.seq       sif
);
  import io_map_pkg::*;

  scan_state_e state_q, state_d;
  logic [4:0]  idx_q, idx_d;
  logic        cur_sel;

  assign cur_sel        = sif.chan_enable[idx_q[3:0]];
  assign sif.busy       = (state_q == SCAN_RUN);
  assign sif.chan_valid = (state_q == SCAN_RUN) && cur_sel;
  assign sif.chan       = idx_q[3:0];
  assign sif.done       = (state_q == SCAN_DONE);

  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    unique case (state_q)
      SCAN_IDLE: begin
        if (sif.start) begin
          state_d = SCAN_RUN;
          idx_d   = 5'h00;
        end
      end
      SCAN_RUN: begin
        // Unselected channels pass in one cycle, no output
        if (idx_q == 5'h0f) begin
          state_d = SCAN_DONE;
        end else begin
          idx_d = idx_q + 5'h01;
        end
      end
      SCAN_DONE: state_d = SCAN_IDLE;
      default:   state_d = SCAN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SCAN_IDLE;
      idx_q   <= 5'h00;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
    end
  end

  skip_unsel_a: assert property (@(posedge clk) disable iff (!rst_b)
    sif.chan_valid |-> sif.busy && sif.chan_enable[sif.chan])
    else $error("unselected channel presented");

  scan_order_a: assert property (@(posedge clk) disable iff (!rst_b)
    sif.busy && sif.chan != 4'hf |=> sif.busy
    && sif.chan == $past(sif.chan) + 4'h1)
    else $error("scan skipped or repeated a channel");

  scan_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == SCAN_IDLE && sif.start) |-> ##17 sif.done)
    else $error("scan did not take sixteen cycles");
endmodule // scan_seq

// ==== rtl/io_ref_mapper.sv ====
// Expanded-mode discrete reference to memory location mapper
// ==========================================================
// Function
// - Sixteen channels; 0-7 main, 8-F auxiliary
// - Reference: channel, type, real flag, point
// - Channels 0 and 8 use plain ranges
// - Coded real refs of 0/8 never physical
// - 64 words per channel per type
// - Points 1001-1024 reserved, not physical
// - Plain channel 0 real goes to main status table
// - Plain channel 8 real in registers 1-128
// - Real blocks from 129 and 1153
// - Register mapping only with 8K or 16K
// - Override only for plain main/aux refs
// - Transition only for plain output refs
// - Internal points from 2049 and 3073
// - Internal points never physical
// - Unused locations stay internal storage
// - Scanner steps all 16 channels, flags only selected ones
// - Allocation in 1K-in plus 1K-out channels
`timescale 1ns/1ps
`include "io_map_cfg.svh"
module io_ref_mapper (
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Reference request
  input  wire logic                req_valid,
  input  wire io_map_pkg::chan_t   req_chan,
  input  wire logic                req_is_output,
  input  wire logic                req_is_real,
  input  wire logic                req_plain,
  input  wire io_map_pkg::point_t  req_point,
  input  wire logic                reg_mem_large,
  // Mapped answer
  output logic                     map_valid,
  output io_map_pkg::dest_e        map_dest,
  output io_map_pkg::reg_num_t     map_word,
  output logic [3:0]               map_bit,
  output logic                     map_physical,
  output logic                     map_has_override,
  output logic                     map_has_transition,
  output logic                     map_error,
  // Channel scan
  input  wire logic                scan_start,
  input  wire logic [15:0]         chan_enable,
  output logic                     scan_busy,
  output logic                     scan_chan_valid,
  output io_map_pkg::chan_t        scan_chan,
  output logic                     scan_done
);
  import io_map_pkg::*;

  // ========================================================
  // Reference decode
  logic       is_aux;
  logic [9:0] pt0;
  logic       pt_ok;
  logic       coded_edge;
  logic [2:0] chan_low;

  assign is_aux     = req_chan[3];
  assign chan_low   = req_chan[2:0];
  assign pt_ok      = (req_point != 11'd0) && (req_point <= `LAST_POINT);
  assign pt0        = 10'(req_point - 11'd1);
  // Plain form exists only for channels 0 and 8
  assign coded_edge = req_is_real && !req_plain && (chan_low == 3'h0);

  // ========================================================
  // Word offset within region
  reg_num_t word_in_blk;
  reg_num_t real_blk_base;
  reg_num_t int_blk_base;
  reg_num_t real_word;
  reg_num_t int_word;
  reg_num_t aux_word;
  reg_num_t type_off;

  assign word_in_blk = {7'h00, pt0[9:4]};
  assign type_off    = req_is_output ? 13'd0 : `WORDS_PER_TYPE;
  // Main real channels 1-7 from 129, aux 9-F from 1153
  assign real_blk_base = (is_aux ? `AUX_REAL_BASE : `MAIN_REAL_BASE)
                       + 13'({chan_low - 3'h1, 7'h00});
  assign int_blk_base  = (is_aux ? `AUX_INT_BASE : `MAIN_INT_BASE)
                       + 13'({chan_low, 7'h00});
  assign real_word = real_blk_base + type_off + word_in_blk;
  assign int_word  = int_blk_base + type_off + word_in_blk;
  assign aux_word  = `AUX_TABLE_BASE + type_off + word_in_blk;

  // ========================================================
  // Destination selection
  logic   plain_bad;
  logic   err_d;
  logic   int_path;
  dest_e  dest_d;
  reg_num_t word_d;

  assign plain_bad = req_plain && (!req_is_real || chan_low != 3'h0);
  // Coded refs of 0/8 fall back to internal program bits
  assign int_path  = !req_is_real || coded_edge;
  assign err_d     = !pt_ok || plain_bad
                   || (!req_plain && !reg_mem_large);

  assign dest_d = err_d ? DEST_INVALID :
                  req_plain ? (is_aux ? DEST_AUX_STATUS
                                      : DEST_MAIN_STATUS) :
                  int_path ? DEST_INT_REG : DEST_REAL_REG;
  assign word_d = err_d ? 13'd0 :
                  (req_plain && !is_aux) ? word_in_blk + type_off :
                  req_plain ? aux_word :
                  int_path ? int_word : real_word;

  logic phys_d;
  logic ovr_d;
  logic trn_d;
  assign phys_d = !err_d && !int_path
                && (req_point <= `LAST_REAL_POINT);
  assign ovr_d  = !err_d && req_plain;
  assign trn_d  = !err_d && req_plain && req_is_output;

  // ========================================================
  // Answer registers, one cycle after request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      map_valid          <= 1'b0;
      map_dest           <= DEST_INVALID;
      map_word           <= 13'd0;
      map_bit            <= 4'h0;
      map_physical       <= 1'b0;
      map_has_override   <= 1'b0;
      map_has_transition <= 1'b0;
      map_error          <= 1'b0;
    end else begin
      map_valid          <= req_valid;
      if (req_valid) begin
        map_dest           <= dest_d;
        map_word           <= word_d;
        map_bit            <= pt0[3:0];
        map_physical       <= phys_d;
        map_has_override   <= ovr_d;
        map_has_transition <= trn_d;
        map_error          <= err_d;
      end
    end
  end

  // ========================================================
  // Channel scan
  scan_if sif ();
  assign sif.start       = scan_start;
  assign sif.chan_enable = chan_enable;
  assign scan_busy       = sif.busy;
  assign scan_chan_valid = sif.chan_valid;
  assign scan_chan       = sif.chan;
  assign scan_done       = sif.done;

  scan_seq u_seq (
    .clk   (clk),
    .rst_b (rst_b),
    .sif   (sif)
  );

  // ========================================================
  // Checks
  ch0_main_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid && req_plain && req_is_real && req_chan == 4'h0 && pt_ok
    |=> map_dest == DEST_MAIN_STATUS)
    else $error("channel 0 plain not in main table");

  ch8_regs_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid && req_plain && req_is_real && req_chan == 4'h8 && pt_ok
    |=> map_dest == DEST_AUX_STATUS && map_word >= 13'd1
        && map_word <= 13'd128)
    else $error("channel 8 outside registers 1-128");

  coded_edge_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid && coded_edge |=> !map_physical)
    else $error("coded channel 0/8 ref made physical");

  reserved_pt_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid && req_point > 11'd1000 |=> !map_physical)
    else $error("reserved point made physical");

  real_range_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid && !err_d && dest_d == DEST_REAL_REG
    |=> map_word >= 13'd129 && map_word <= 13'd2048)
    else $error("real word out of range");

  int_range_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid && !err_d && !req_is_real
    |=> map_word >= 13'd2049 && map_word <= 13'd4096
        && !map_physical)
    else $error("internal word out of range");

  small_mem_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid && !req_plain && !reg_mem_large |=> map_error)
    else $error("mapping used with small register memory");

  tables_a: assert property (@(posedge clk) disable iff (!rst_b)
    map_has_transition |-> map_has_override)
    else $error("transition table without override table");

  bit_pos_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid |=> map_bit == $past(req_point[3:0] - 4'h1))
    else $error("bit position wrong");

  ovr_plain_a: assert property (@(posedge clk) disable iff (!rst_b)
    map_valid && map_has_override
    |-> !map_error && map_dest inside {DEST_MAIN_STATUS, DEST_AUX_STATUS})
    else $error("override table on coded reference");

  trn_output_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid && !req_is_output |=> !map_has_transition)
    else $error("transition table on input reference");

  int_phys_a: assert property (@(posedge clk) disable iff (!rst_b)
    map_valid && map_dest == DEST_INT_REG |-> !map_physical)
    else $error("internal point made physical");

  ch8_coded_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid && req_chan == 4'h8 && req_is_real && !req_plain
    && reg_mem_large && pt_ok
    |=> map_dest == DEST_INT_REG && map_word >= 13'd3073
        && map_word <= 13'd3200)
    else $error("coded channel 8 ref not in internal region");
endmodule // io_ref_mapper

// ==== bench/scan_host.sv ====
// CPU-side scan requester model facing the channel scanner
`timescale 1ns/1ps
module scan_host (
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic        chan_valid,
  input  wire logic [3:0]  chan,
  input  wire logic        done,
  output logic             start,
  output logic [15:0]      enable
);
  initial begin
    start  = 1'b0;
    enable = 16'h0000;
  end
  // ==========================================================
  // One scan: channels seen and a framing verdict
  task automatic run(input logic [15:0] sel, output logic [15:0] seen,
                     output logic ok);
    @(posedge clk);
    start  <= 1'b1;
    enable <= sel;
    @(posedge clk);
    start <= 1'b0;
    seen = 16'h0000;
    ok   = 1'b1;
    for (int k = 0; k < 17; k++) begin
      // Sample k follows the k-th edge after the start edge
      if (k > 0) @(posedge clk);
      #1;
      if (k < 16) begin
        if (busy !== 1'b1 || chan !== k[3:0] || done !== 1'b0) ok = 1'b0;
        if (chan_valid === 1'b1) seen[k] = 1'b1;
      end else if (done !== 1'b1 || busy !== 1'b0) begin
        ok = 1'b0;
      end
    end
  endtask
endmodule // scan_host

// ==== bench/testbench.sv ====
// Self-checking bench for the expanded-mode reference mapper
`timescale 1ns/1ps
module testbench;
  import io_map_pkg::*;
  typedef struct packed {
    logic [18:0] q;
    dest_e       d;
    reg_num_t    w;
    logic [3:0]  b;
    logic [3:0]  f;
  } row_s;
  localparam int NROWS = 13;
  logic        clk, rst_b, req_valid, req_is_output, req_is_real, req_plain;
  logic        reg_mem_large, map_valid, map_physical, map_has_override;
  logic        map_has_transition, map_error, scan_start, scan_busy;
  logic        scan_chan_valid, scan_done, ok;
  chan_t       req_chan, scan_chan;
  point_t      req_point;
  dest_e       map_dest;
  reg_num_t    map_word;
  logic [3:0]  map_bit;
  logic [15:0] chan_enable, seen;
  row_s        rows [NROWS];
  int          miscompares;
  int          comparisons;

  io_ref_mapper uut (.clk, .rst_b, .req_valid, .req_chan, .req_is_output,
    .req_is_real, .req_plain, .req_point, .reg_mem_large, .map_valid,
    .map_dest, .map_word, .map_bit, .map_physical, .map_has_override,
    .map_has_transition, .map_error, .scan_start, .chan_enable, .scan_busy,
    .scan_chan_valid, .scan_chan, .scan_done);
  scan_host host (.clk, .busy(scan_busy), .chan_valid(scan_chan_valid),
    .chan(scan_chan), .done(scan_done), .start(scan_start),
    .enable(chan_enable));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  function automatic row_s mk(chan_t ch, logic [2:0] t, point_t pt,
    logic lg, dest_e d, reg_num_t w, logic [3:0] b, logic [3:0] f);
    return '{{ch, t, pt, lg}, d, w, b, f};
  endfunction
  function automatic logic row_ok(row_s e);
    logic [3:0] fl;
    fl = {map_physical, map_has_override, map_has_transition, map_error};
    if (map_valid !== 1'b1 || map_dest !== e.d || map_error !== e.f[0])
      return 1'b0;
    if (e.f[0]) return 1'b1;
    return map_word === e.w && map_bit === e.b && fl === e.f;
  endfunction
  task automatic check(input logic c, input string m);
    comparisons++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
  // ==========================================================
  // Rows: {out,real,plain}, flags {physical,override,transition,error}
  initial begin
    rows[0]  = mk(4'h3, 3'b110, 11'h001, 1'b1,
                  DEST_REAL_REG, 13'h181, 4'h0, 4'h8);
    rows[1]  = mk(4'hf, 3'b010, 11'h3e8, 1'b1,
                  DEST_REAL_REG, 13'h7ff, 4'h7, 4'h8);
    rows[2]  = mk(4'h1, 3'b010, 11'h3e9, 1'b1,
                  DEST_REAL_REG, 13'h0ff, 4'h8, 4'h0);
    rows[3]  = mk(4'h0, 3'b000, 11'h400, 1'b1,
                  DEST_INT_REG, 13'h880, 4'hf, 4'h0);
    rows[4]  = mk(4'h9, 3'b100, 11'h011, 1'b1,
                  DEST_INT_REG, 13'hc82, 4'h0, 4'h0);
    rows[5]  = mk(4'h0, 3'b111, 11'h005, 1'b1,
                  DEST_MAIN_STATUS, 13'h0, 4'h4, 4'he);
    rows[6]  = mk(4'h8, 3'b011, 11'h021, 1'b1,
                  DEST_AUX_STATUS, 13'h43, 4'h0, 4'hc);
    rows[7]  = mk(4'h8, 3'b110, 11'h001, 1'b1,
                  DEST_INT_REG, 13'hc01, 4'h0, 4'h0);
    rows[8]  = mk(4'h0, 3'b011, 11'h400, 1'b0,
                  DEST_MAIN_STATUS, 13'h7f, 4'hf, 4'h4);
    rows[9]  = mk(4'h3, 3'b110, 11'h001, 1'b0,
                  DEST_INVALID, 13'h0, 4'h0, 4'h1);
    rows[10] = mk(4'h3, 3'b111, 11'h001, 1'b1,
                  DEST_INVALID, 13'h0, 4'h0, 4'h1);
    rows[11] = mk(4'h2, 3'b010, 11'h000, 1'b1,
                  DEST_INVALID, 13'h0, 4'h0, 4'h1);
    rows[12] = mk(4'h2, 3'b010, 11'h401, 1'b1,
                  DEST_INVALID, 13'h0, 4'h0, 4'h1);
    rst_b = 1'b0;
    req_valid = 1'b0;
    {req_chan, req_is_output, req_is_real, req_plain, req_point} = '0;
    reg_mem_large = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // Back to back, each answer one cycle behind its request
    for (int i = 0; i <= NROWS; i++) begin
      @(posedge clk);
      req_valid <= (i < NROWS);
      if (i < NROWS) begin
        {req_chan, req_is_output, req_is_real, req_plain, req_point,
         reg_mem_large} <= rows[i].q;
      end
      #1;
      if (i > 0) check(row_ok(rows[i-1]), "mapping mismatch");
    end
    @(posedge clk);
    #1;
    check(map_valid === 1'b0 && map_dest === DEST_INVALID, "no hold");
    $display("test mapping rows done");
    // Every channel is stepped, only selected ones flagged, starts back to back
    foreach (rows[i]) begin
      if (i < 3) begin
        host.run(i == 0 ? 16'h0101 : i == 1 ? 16'hfffe : 16'h8000, seen, ok);
        check(ok === 1'b1 && seen === host.enable, "scan wrong");
      end
    end
    $display("test scan done");
    // Reset lands on the edge that takes a request
    @(posedge clk);
    req_valid <= 1'b1;
    {req_chan, req_is_output, req_is_real, req_plain, req_point,
     reg_mem_large} <= rows[5].q;
    @(posedge clk);
    req_valid <= 1'b0;
    rst_b <= 1'b0;
    #1;
    check(map_valid === 1'b0 && map_dest === DEST_INVALID && map_word === 13'h0
      && scan_busy === 1'b0 && scan_done === 1'b0, "reset values");
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    check(row_ok(rows[5]), "after reset");
    $display("test reset done");
    give_verdict();
  end
endmodule // testbench
